// ### rtl/spqa_pkg.sv
// Shared constants and types for the switch port queue arbiter
package spqa_pkg;
  localparam int QDEPTH = 8;
  localparam int IDXW = 3;
  localparam int PRIOW = 2;
  localparam int DESTW = 3;
  localparam int NDEST = 8;
  localparam int WMW = 4;
  localparam int CNTW = 16;
  localparam logic [3:0] QFULL = 4'h8;
  localparam logic [1:0] TOP_PRIO = 2'h3;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] WM_OFS = 12'h004;
  localparam logic [11:0] LIMIT_OFS = 12'h008;
  localparam logic [11:0] RCOUNT_OFS = 12'h00C;
  localparam logic [11:0] RTHRESH_OFS = 12'h010;
  localparam logic [11:0] STATUS_OFS = 12'h014;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LIMEN_BIT = 2;
  localparam int CTRL_IRQEN_BIT = 3;
  localparam int CTRL_PDOWN_BIT = 4;
  localparam int WM0_LSB = 0;
  localparam int WM1_LSB = 4;
  localparam int WM2_LSB = 8;
  localparam int STAT_EGR_LSB = 8;
  localparam logic [1:0] MODE_ARRIVAL = 2'h0;
  localparam logic [1:0] MODE_STRICT1 = 2'h1;
  localparam logic [1:0] MODE_STRICT2 = 2'h2;
  localparam logic [3:0] WM0_RESET = 4'h3;
  localparam logic [3:0] WM1_RESET = 4'h2;
  localparam logic [3:0] WM2_RESET = 4'h1;
  localparam logic [3:0] LIMIT_RESET = 4'h4;
  localparam logic [15:0] RTHRESH_RESET = 16'hFFFF;
  typedef logic [IDXW-1:0] spqa_idx_t;
  typedef logic [PRIOW-1:0] spqa_prio_t;
  typedef logic [DESTW-1:0] spqa_dest_t;
endpackage

// ### rtl/spqa_queue_if.sv
// Ingress queue view shared between the queue owner and the picker
interface spqa_queue_if;
  import spqa_pkg::*;
  logic [QDEPTH-1:0] valid;
  logic [QDEPTH-1:0] ready;
  logic [QDEPTH-1:0] barred;
  spqa_prio_t prio [QDEPTH];
  logic [1:0] mode;
  logic selValid;
  spqa_idx_t selIdx;
  modport owner (output valid, ready, barred, prio, mode, input selValid, selIdx);
  modport picker (input valid, ready, barred, prio, mode, output selValid, selIdx);
endinterface

// ### rtl/spqa_picker.sv
// Input arbitration: picks the ingress entry offered to the fabric
module spqa_picker
(
  spqa_queue_if.picker q
);
  import spqa_pkg::*;

  logic [QDEPTH-1:0] elig;
  logic [QDEPTH-1:0] go;
  logic [QDEPTH-1:0] selMask;

  function automatic logic [QDEPTH-1:0] prioMask(input logic [PRIOW-1:0] p,
                                                 input logic [QDEPTH-1:0] m);
    logic [QDEPTH-1:0] r;
    r = '0;
    for (int i = 0; i < QDEPTH; i++)
    begin
      r[i] = m[i] && (q.prio[i] == p);
    end
    return r;
  endfunction

  always_comb
  begin
    elig = q.valid & ~q.barred;
    go = elig & q.ready;
    selMask = '0;
    case (q.mode)
      MODE_STRICT1:
      begin
        for (int p = 3; p >= 0; p--)
        begin
          if (selMask == '0)
            selMask = prioMask(PRIOW'(p), go);
        end
        for (int p = 3; p >= 0; p--)
        begin
          if (selMask == '0)
            selMask = prioMask(PRIOW'(p), elig);
        end
      end
      MODE_STRICT2:
      begin
        for (int p = 3; p >= 0; p--)
        begin
          if (selMask == '0)
            selMask = prioMask(PRIOW'(p), go);
          if (selMask == '0)
            selMask = prioMask(PRIOW'(p), elig);
        end
      end
      default:
      begin
        selMask = go;
        if (selMask == '0)
          selMask = elig;
      end
    endcase
    q.selValid = |selMask;
    q.selIdx = '0;
    for (int i = QDEPTH - 1; i >= 0; i--)
    begin
      if (selMask[i])
        q.selIdx = IDXW'(i);
    end
  end
endmodule

// ### rtl/spqa_egress.sv
// Egress output queue toward the link partner
module spqa_egress
  import spqa_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic powerDown,
  input wire logic inValid,
  input wire spqa_prio_t inPrio,
  output logic inReady,
  output logic txValid,
  output spqa_prio_t txPrio,
  input wire logic linkAck,
  input wire logic linkRetry,
  output logic [3:0] count
);
  logic [QDEPTH-1:0] valid_q;
  logic [QDEPTH-1:0] sent_q;
  spqa_prio_t prio_q [QDEPTH];
  logic [3:0] cnt_q;
  logic retrans_q;
  logic accept;
  logic remove;
  logic doTx;
  spqa_idx_t ackIdx;
  spqa_idx_t txIdx;
  logic [3:0] cntAfter;
  logic [QDEPTH-1:0] unsent;

  always_comb
  begin
    unsent = valid_q & ~sent_q;
    accept = inValid && inReady;
    ackIdx = '0;
    for (int i = QDEPTH - 1; i >= 0; i--)
    begin
      if (valid_q[i] && sent_q[i])
        ackIdx = IDXW'(i);
    end
    remove = linkAck && |(valid_q & sent_q) && !powerDown;
    txIdx = '0;
    for (int i = QDEPTH - 1; i >= 0; i--)
    begin
      if (unsent[i])
        txIdx = IDXW'(i);
    end
    if (retrans_q)
    begin
      for (int p = 0; p < 4; p++)
      begin
        for (int i = QDEPTH - 1; i >= 0; i--)
        begin
          if (unsent[i] && prio_q[i] == PRIOW'(p))
            txIdx = IDXW'(i);
        end
      end
    end
    doTx = |unsent && !powerDown && !linkRetry;
    cntAfter = cnt_q - {3'h0, remove};
  end

  genvar g;
  generate
    for (g = 0; g < QDEPTH; g++)
    begin : gEntry
      localparam int NXT = (g + 1) % QDEPTH;
      always_ff @(posedge clock)
      begin
        if (reset || powerDown)
        begin
          valid_q[g] <= 1'b0;
          sent_q[g] <= 1'b0;
          prio_q[g] <= '0;
        end
        else if (accept && cntAfter == 4'(g))
        begin
          valid_q[g] <= 1'b1;
          sent_q[g] <= 1'b0;
          prio_q[g] <= inPrio;
        end
        else if (remove && IDXW'(g) >= ackIdx)
        begin
          if (g == QDEPTH - 1)
            valid_q[g] <= 1'b0;
          else
          begin
            valid_q[g] <= valid_q[NXT];
            sent_q[g] <= !linkRetry && (sent_q[NXT] || (doTx && txIdx == IDXW'(NXT)));
            prio_q[g] <= prio_q[NXT];
          end
        end
        else
          sent_q[g] <= !linkRetry && (sent_q[g] || (doTx && txIdx == IDXW'(g)));
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (reset || powerDown)
      cnt_q <= '0;
    else
      cnt_q <= cntAfter + {3'h0, accept};
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      retrans_q <= 1'b0;
    else if (linkRetry)
      retrans_q <= 1'b1;
    else if (doTx)
      retrans_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      inReady <= 1'b0;
    else
      inReady <= powerDown || (cntAfter + {3'h0, accept} < QFULL && !accept);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      txValid <= 1'b0;
      txPrio <= '0;
    end
    else
    begin
      txValid <= doTx;
      txPrio <= prio_q[txIdx];
    end
  end

  assign count = cnt_q;
endmodule

// ### rtl/spqa_top.sv
// Switch port ingress queue, input arbiter, reorder counter and APB registers
module spqa_top
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxStart,
  input wire spqa_pkg::spqa_prio_t rxPrio,
  input wire spqa_pkg::spqa_dest_t rxDest,
  output logic retrySymbol,
  input wire logic [spqa_pkg::NDEST-1:0] destReady,
  input wire logic fabricGrant,
  output logic offerValid,
  output spqa_pkg::spqa_dest_t offerDest,
  output spqa_pkg::spqa_prio_t offerPrio,
  input wire logic egrInValid,
  input wire spqa_pkg::spqa_prio_t egrInPrio,
  output logic egrInReady,
  output logic txValid,
  output spqa_pkg::spqa_prio_t txPrio,
  input wire logic linkAck,
  input wire logic linkRetry,
  output logic reorderThresholdIrq
);
  import spqa_pkg::*;

  // Control registers
  logic [1:0] inputArbitrationSelect_q;
  logic limitEn_q;
  logic irqEn_q;
  logic powerDown_q;
  logic [WMW-1:0] level0FreeThreshold_q;
  logic [WMW-1:0] level1FreeThreshold_q;
  logic [WMW-1:0] level2FreeThreshold_q;
  logic [WMW-1:0] limit_q;
  logic [CNTW-1:0] reorderEventCount_q;
  logic [CNTW-1:0] reorderThreshold_q;

  // Ingress queue storage
  logic [QDEPTH-1:0] valid_q;
  spqa_prio_t prio_q [QDEPTH];
  spqa_dest_t dest_q [QDEPTH];
  logic [WMW-1:0] allow_q [QDEPTH];
  logic [3:0] cnt_q;
  spqa_idx_t offerIdx_q;

  logic apbWrite;
  logic apbSetup;
  logic [3:0] freeCount;
  logic admit;
  logic granted;
  logic reorder;
  logic [3:0] cntAfter;
  logic [CNTW-1:0] countNext;
  logic [31:0] readData;
  logic addrHit;
  logic [3:0] egrCount;

  spqa_queue_if q ();

  spqa_picker uPicker
  (
    .q(q)
  );

  spqa_egress uEgress
  (
    .clock(clock),
    .reset(reset),
    .powerDown(powerDown_q),
    .inValid(egrInValid),
    .inPrio(egrInPrio),
    .inReady(egrInReady),
    .txValid(txValid),
    .txPrio(txPrio),
    .linkAck(linkAck),
    .linkRetry(linkRetry),
    .count(egrCount)
  );

  // Queue view for the picker
  genvar g;
  generate
    for (g = 0; g < QDEPTH; g++)
    begin : gView
      logic barredHere;
      always_comb
      begin
        barredHere = 1'b0;
        for (int j = 0; j < g; j++)
        begin
          if (limitEn_q && valid_q[j] && allow_q[j] == '0 && prio_q[j] >= prio_q[g])
            barredHere = 1'b1;
        end
      end
      assign q.valid[g] = valid_q[g];
      assign q.prio[g] = prio_q[g];
      assign q.ready[g] = destReady[dest_q[g]];
      assign q.barred[g] = barredHere;
    end
  endgenerate

  assign q.mode = inputArbitrationSelect_q;

  // Admission against free buffers
  always_comb
  begin
    granted = fabricGrant && offerValid;
    reorder = granted && offerIdx_q != '0;
    cntAfter = cnt_q - {3'h0, granted};
    freeCount = QFULL - cnt_q;
    case (rxPrio)
      2'h0: admit = freeCount > level0FreeThreshold_q;
      2'h1: admit = freeCount > level1FreeThreshold_q;
      2'h2: admit = freeCount > level2FreeThreshold_q;
      default: admit = freeCount != 4'h0;
    endcase
    admit = admit && rxStart;
    countNext = reorderEventCount_q + 16'h0001;
  end

  // Ingress entries with compaction on removal
  generate
    for (g = 0; g < QDEPTH; g++)
    begin : gEntry
      localparam int NXT = (g + 1) % QDEPTH;
      logic hitAllow;
      always_comb
      begin
        hitAllow = reorder && limitEn_q && IDXW'(g) < offerIdx_q &&
                   prio_q[g] >= offerPrio && allow_q[g] != '0;
      end
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          valid_q[g] <= 1'b0;
          prio_q[g] <= '0;
          dest_q[g] <= '0;
          allow_q[g] <= '0;
        end
        else if (admit && cntAfter == 4'(g))
        begin
          valid_q[g] <= 1'b1;
          prio_q[g] <= rxPrio;
          dest_q[g] <= rxDest;
          allow_q[g] <= limit_q;
        end
        else if (granted && IDXW'(g) >= offerIdx_q)
        begin
          if (g == QDEPTH - 1)
            valid_q[g] <= 1'b0;
          else
          begin
            valid_q[g] <= valid_q[NXT];
            prio_q[g] <= prio_q[NXT];
            dest_q[g] <= dest_q[NXT];
            allow_q[g] <= allow_q[NXT];
          end
        end
        else if (hitAllow)
          allow_q[g] <= allow_q[g] - 4'h1;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (reset)
      cnt_q <= '0;
    else
      cnt_q <= cntAfter + {3'h0, admit};
  end

  // Retry symbol on a refused packet, one cycle after its first bytes
  always_ff @(posedge clock)
  begin
    if (reset)
      retrySymbol <= 1'b0;
    else
      retrySymbol <= rxStart && !admit;
  end

  // Offer toward the fabric
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      offerValid <= 1'b0;
      offerIdx_q <= '0;
      offerDest <= '0;
      offerPrio <= '0;
    end
    else
    begin
      offerValid <= q.selValid && !granted;
      offerIdx_q <= q.selIdx;
      offerDest <= dest_q[q.selIdx];
      offerPrio <= prio_q[q.selIdx];
    end
  end

  // Reorder counter and threshold interrupt
  always_ff @(posedge clock)
  begin
    if (reset)
      reorderEventCount_q <= '0;
    else if (reorder)
      reorderEventCount_q <= countNext;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      reorderThresholdIrq <= 1'b0;
    else
      reorderThresholdIrq <= reorder && irqEn_q && countNext == reorderThreshold_q;
  end

  // APB access
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite && !pslverr;

  always_comb
  begin
    addrHit = 1'b1;
    readData = '0;
    case (paddr)
      CTRL_OFS:
      begin
        readData[CTRL_MODE_LSB +: 2] = inputArbitrationSelect_q;
        readData[CTRL_LIMEN_BIT] = limitEn_q;
        readData[CTRL_IRQEN_BIT] = irqEn_q;
        readData[CTRL_PDOWN_BIT] = powerDown_q;
      end
      WM_OFS:
      begin
        readData[WM0_LSB +: WMW] = level0FreeThreshold_q;
        readData[WM1_LSB +: WMW] = level1FreeThreshold_q;
        readData[WM2_LSB +: WMW] = level2FreeThreshold_q;
      end
      LIMIT_OFS: readData[WMW-1:0] = limit_q;
      RCOUNT_OFS: readData[CNTW-1:0] = reorderEventCount_q;
      RTHRESH_OFS: readData[CNTW-1:0] = reorderThreshold_q;
      STATUS_OFS:
      begin
        readData[3:0] = cnt_q;
        readData[STAT_EGR_LSB +: 4] = egrCount;
      end
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup && !addrHit;
      prdata <= (apbSetup && !pwrite) ? readData : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      inputArbitrationSelect_q <= MODE_ARRIVAL;
      limitEn_q <= 1'b0;
      irqEn_q <= 1'b0;
      powerDown_q <= 1'b0;
    end
    else if (apbWrite && paddr == CTRL_OFS)
    begin
      inputArbitrationSelect_q <= pwdata[CTRL_MODE_LSB +: 2];
      limitEn_q <= pwdata[CTRL_LIMEN_BIT];
      irqEn_q <= pwdata[CTRL_IRQEN_BIT];
      powerDown_q <= pwdata[CTRL_PDOWN_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      level0FreeThreshold_q <= WM0_RESET;
      level1FreeThreshold_q <= WM1_RESET;
      level2FreeThreshold_q <= WM2_RESET;
    end
    else if (apbWrite && paddr == WM_OFS)
    begin
      level0FreeThreshold_q <= pwdata[WM0_LSB +: WMW];
      level1FreeThreshold_q <= pwdata[WM1_LSB +: WMW];
      level2FreeThreshold_q <= pwdata[WM2_LSB +: WMW];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      limit_q <= LIMIT_RESET;
    else if (apbWrite && paddr == LIMIT_OFS)
      limit_q <= pwdata[WMW-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      reorderThreshold_q <= RTHRESH_RESET;
    else if (apbWrite && paddr == RTHRESH_OFS)
      reorderThreshold_q <= pwdata[CNTW-1:0];
  end
endmodule

// ### tb/spqa_checker.sv
// Port-level assertions for the switch port queue arbiter
module spqa_checker
  import spqa_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic rxStart,
  input wire spqa_prio_t rxPrio,
  input wire logic retrySymbol,
  input wire logic fabricGrant,
  input wire logic offerValid,
  input wire logic egrInValid,
  input wire logic egrInReady,
  input wire logic txValid,
  input wire logic reorderThresholdIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  int occ_q;
  int occNow;
  logic rxPend_q;
  logic pdown_q;
  logic grantTaken;
  assign grantTaken = offerValid && fabricGrant;
  assign occNow = occ_q + int'(rxPend_q && !retrySymbol);
  always_ff @(posedge clock)
  begin
    rxPend_q <= !reset && rxStart;
    occ_q <= reset ? 0 : occNow - int'(grantTaken);
    if (reset)
      pdown_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
      pdown_q <= pwdata[CTRL_PDOWN_BIT];
  end
  property p_retry_cause;
    retrySymbol |-> $past(rxStart);
  endproperty
  a_retry_cause: assert property (p_retry_cause) else $error("retry without arrival");
  property p_full_refuse;
    rxStart && occNow >= QDEPTH |=> retrySymbol;
  endproperty
  a_full_refuse: assert property (p_full_refuse) else $error("full queue admitted");
  property p_top_admit;
    rxStart && rxPrio == TOP_PRIO && occNow < QDEPTH |=> !retrySymbol;
  endproperty
  a_top_admit: assert property (p_top_admit) else $error("top priority refused");
  property p_egr_one;
    !pdown_q && egrInValid && egrInReady |=> !egrInReady;
  endproperty
  a_egr_one: assert property (p_egr_one) else $error("egress took two at once");
  property p_offer_gap;
    grantTaken |=> !offerValid;
  endproperty
  a_offer_gap: assert property (p_offer_gap) else $error("offer held after grant");
  property p_no_offer_empty;
    occNow == 0 |=> !offerValid;
  endproperty
  a_no_offer_empty: assert property (p_no_offer_empty) else $error("offer from empty queue");
  property p_irq_cause;
    reorderThresholdIrq |-> $past(grantTaken) || $past(grantTaken, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without reorder");
  property p_irq_pulse;
    reorderThresholdIrq |=> !reorderThresholdIrq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a pulse");
  property p_pd_quiet;
    pdown_q && $past(pdown_q) |-> !txValid;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("powered down port sent");
  c_refuse: cover property (retrySymbol);
  c_grant: cover property (grantTaken);
  c_irq: cover property (reorderThresholdIrq);
  c_tx: cover property (txValid);
endmodule

bind spqa_top spqa_checker uChk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .rxStart(rxStart), .rxPrio(rxPrio), .retrySymbol(retrySymbol), .fabricGrant(fabricGrant),
  .offerValid(offerValid), .egrInValid(egrInValid), .egrInReady(egrInReady),
  .txValid(txValid), .reorderThresholdIrq(reorderThresholdIrq));

// ### tb/spqa_partner.sv
// Fabric and link partner model facing the arbiter
module spqa_partner
  import spqa_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [NDEST-1:0] openMask,
  input wire logic grantEn,
  input wire logic ackEn,
  input wire logic retryReq,
  input wire logic offerValid,
  input wire spqa_dest_t offerDest,
  input wire logic txValid,
  output logic [NDEST-1:0] destReady,
  output logic fabricGrant,
  output logic linkAck,
  output logic linkRetry
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock)
  begin
    destReady <= reset ? '0 : openMask;
    fabricGrant <= !reset && grantEn && offerValid && !fabricGrant && destReady[offerDest];
    linkAck <= !reset && ackEn && txValid;
    linkRetry <= !reset && retryReq && !linkRetry;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the switch port queue arbiter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spqa_pkg::*;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
  logic clock, reset, psel, penable, pwrite, rxStart, egrInValid, grantEn, ackEn, retryReq;
  logic pready, pslverr, err, retrySymbol, fabricGrant, offerValid, egrInReady, txValid;
  logic linkAck, linkRetry, reorderThresholdIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  spqa_prio_t rxPrio, egrInPrio, offerPrio, txPrio;
  spqa_dest_t rxDest, offerDest;
  logic [NDEST-1:0] destReady, openMask;
  int bad_count, compares, seed, occ, reorders, irqs;
  int wm [3];
  spqa_prio_t qp[$], txLog[$];
  spqa_dest_t qd[$];
  spqa_prio_t egrLog[$];
  int qa[$];
  int lim, limOn;
  spqa_top uut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxStart(rxStart), .rxPrio(rxPrio), .rxDest(rxDest),
    .retrySymbol(retrySymbol), .destReady(destReady), .fabricGrant(fabricGrant),
    .offerValid(offerValid), .offerDest(offerDest), .offerPrio(offerPrio),
    .egrInValid(egrInValid), .egrInPrio(egrInPrio), .egrInReady(egrInReady),
    .txValid(txValid), .txPrio(txPrio), .linkAck(linkAck), .linkRetry(linkRetry),
    .reorderThresholdIrq(reorderThresholdIrq));
  spqa_partner uPartner (.clock(clock), .reset(reset), .openMask(openMask),
    .grantEn(grantEn), .ackEn(ackEn), .retryReq(retryReq), .offerValid(offerValid),
    .offerDest(offerDest), .txValid(txValid), .destReady(destReady),
    .fabricGrant(fabricGrant), .linkAck(linkAck), .linkRetry(linkRetry));
  initial
  begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (txValid) txLog.push_back(txPrio);
    if (reorderThresholdIrq) irqs++;
  end
  task automatic print_verdict;
    $display("counts: compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang(input string w);
    bad_count++;
    $display("mismatch %s expected handshake seen timeout", w);
    print_verdict();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do @(posedge clock); while (!pready && ++n < 50);
    if (n == 50) hang("pready");
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic rx(input spqa_prio_t p, input spqa_dest_t d);
    logic ok;
    ok = p == TOP_PRIO ? occ < QDEPTH : (QDEPTH - occ) > wm[p];
    rxStart <= 1;
    rxPrio <= p;
    rxDest <= d;
    @(posedge clock);
    rxStart <= 0;
    @(posedge clock);
    `CHK("retry", !ok, retrySymbol)
    if (ok)
    begin
      occ++;
      qp.push_back(p);
      qd.push_back(d);
      qa.push_back(lim);
    end
  endtask
  function automatic int pick(input logic [1:0] md, input logic [NDEST-1:0] m);
    int best, top;
    logic bar;
    best = -1;
    top = 0;
    foreach (qp[i]) if (qp[i] > top) top = qp[i];
    foreach (qp[i])
    begin
      bar = 0;
      for (int j = 0; j < i; j++) bar |= limOn != 0 && qa[j] == 0 && qp[j] >= qp[i];
      if (!bar && m[qd[i]] && (md != MODE_STRICT2 || qp[i] == top)
          && (best < 0 || (md != MODE_ARRIVAL && qp[i] > qp[best]))) best = i;
    end
    return best;
  endfunction
  task automatic step(input logic [1:0] md);
    logic [NDEST-1:0] m;
    int k, n;
    m = NDEST'($random(seed));
    m[qd[$unsigned($random(seed)) % qp.size()]] = 1'b1;
    if (pick(md, m) < 0) m = '1;
    k = pick(md, m);
    openMask <= m;
    repeat (5) @(posedge clock);
    `CHK("offer dest", qd[k], offerDest)
    `CHK("offer prio", qp[k], offerPrio)
    grantEn <= 1;
    n = 0;
    do @(posedge clock); while (!(fabricGrant && offerValid) && ++n < 20);
    grantEn <= 0;
    if (n == 20) hang("grant");
    if (k != 0) reorders++;
    for (int j = 0; j < k; j++) if (limOn != 0 && qp[j] >= qp[k] && qa[j] > 0) qa[j]--;
    qp.delete(k);
    qd.delete(k);
    qa.delete(k);
    occ--;
  endtask
  task automatic egr(input spqa_prio_t p);
    int n;
    egrLog.push_back(p);
    egrInValid <= 1;
    egrInPrio <= p;
    n = 0;
    do @(posedge clock); while (!egrInReady && ++n < 20);
    egrInValid <= 0;
    @(posedge clock);
    if (n == 20) hang("egress accept");
  endtask
  // Retry resends oldest highest priority first, then the rest in arrival order
  function automatic spqa_prio_t txExp(input int i);
    spqa_prio_t r[$];
    int h;
    r = egrLog;
    h = 0;
    if (i < r.size())
      return r[i];
    foreach (r[j]) if (r[j] > r[h]) h = j;
    if (i == r.size())
      return r[h];
    r.delete(h);
    return r[i - r.size() - 2];
  endfunction
  initial
  begin
    seed = 32'hC174C7EA;
    {reset, psel, penable, pwrite, rxStart, egrInValid, grantEn, ackEn, retryReq} = 9'h100;
    {paddr, pwdata, rxPrio, rxDest, egrInPrio, openMask} = '0;
    wm = '{3, 2, 1};
    lim = LIMIT_RESET;
    limOn = 0;
    repeat (4) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    apb(0, WM_OFS, 0);
    `CHK("wm reset", 12'h123, rdata[11:0])
    apb(0, CTRL_OFS, 0);
    `CHK("mode reset", MODE_ARRIVAL, rdata[1:0])
    apb(1, 12'h018, 32'hFFFF_FFFF);
    `CHK("unmapped error", 1'b1, err)
    $display("test registers done");
    apb(1, RTHRESH_OFS, 32'h2);
    for (int i = 0; i < 14; i++) rx(i < 10 ? 2'($random(seed)) : TOP_PRIO, 3'($random(seed)));
    apb(0, STATUS_OFS, 0);
    `CHK("ingress count", 4'(occ), rdata[3:0])
    $display("test admission done");
    for (int md = 0; md < 3; md++)
    begin
      apb(1, CTRL_OFS, 32'h8 | md);
      repeat (3) if (qp.size() > 0) step(2'(md));
      repeat (3) rx(2'($random(seed)), 3'($random(seed)));
    end
    apb(1, LIMIT_OFS, 0);
    lim = 0;
    apb(1, CTRL_OFS, 32'hF);
    limOn = 1;
    repeat (4) rx(2'($random(seed)), 3'($random(seed)));
    repeat (4) if (qp.size() > 0) step(MODE_ARRIVAL);
    apb(0, RCOUNT_OFS, 0);
    `CHK("reorder count", 16'(reorders), rdata[15:0])
    `CHK("irq count", int'(reorders >= 2), irqs)
    apb(1, WM_OFS, 32'h245);
    wm = '{5, 4, 2};
    repeat (6) rx(2'($random(seed)), 3'($random(seed)));
    $display("test arbitration done");
    egr(0);
    egr(2);
    egr(1);
    repeat (6) @(posedge clock);
    ackEn <= 1;
    retryReq <= 1;
    @(posedge clock);
    retryReq <= 0;
    repeat (12) @(posedge clock);
    `CHK("tx count", 6, txLog.size())
    foreach (txLog[i]) `CHK("tx prio", txExp(i), txLog[i])
    `CHK("retry first", 2'h2, txLog[3])
    $display("test egress done");
    ackEn <= 0;
    egr(1);
    apb(1, CTRL_OFS, 32'h10);
    egr(3);
    egr(0);
    apb(0, STATUS_OFS, 0);
    `CHK("egress flushed", 4'h0, rdata[11:8])
    `CHK("no tx powered down", 7, txLog.size())
    $display("test power down done");
    print_verdict();
  end
endmodule
